// ### design/fsr_regs.sv
// fault record, ignore mask, recovery select and threshold registers
`timescale 1ns/10ps
// Function
// - a 16-bit fault record keeps each fault and warning at its own bit, 15:10 and 4 unused.
// - a record bit set to one holds until the host writes zero, command_a arrives, or reset.
// - record bits set on every trigger whatever the ignore mask says.
// - a 16-bit ignore mask; a one means no protective action and normal switching goes on.
// - with the mask bit zero a triggering fault enters hiccup or latch-off as selected.
// - the ignore mask is read/write as a word and resets to 0049h.
// - a 16-bit recovery select uses bits 9:2 at the record positions; others unused.
// - a recovery select one means hiccup, zero means latch-off.
// - an output overvoltage threshold byte resets to 06h.
// - an output undervoltage threshold byte resets to 01h.
// - an input current regulation threshold byte resets to 07h.
// - an average overcurrent threshold byte resets to 07h.
// - only bits 2:0 of each threshold byte are kept.
// - command_a clears all records and releases the alert; a standing fault sets again at once.
// - command_a does not restart a latched or hiccuping converter.
module fsr_regs (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire fsr_pkg::fsr_req_s REQ,
    input wire logic [15:0] FAULT_IN,
    input wire logic RECOVERY_STRAP_PIN,
    input wire logic HICCUP_DONE,
    output logic [15:0] RDATA,
    output logic RVALID,
    output logic ALERT_OUTPUT,
    output logic PROTECT_ACTIVE,
    output logic HICCUP_ACTIVE,
    output logic LATCH_OFF,
    output fsr_pkg::fsr_thresh_s THRESH
);
    logic [15:0] fault_sync1;
    logic [15:0] fault_sync2;
    logic strap_sync1;
    logic strap_sync2;
    logic strap_loaded;
    logic [1:0] strap_wait;
    logic [15:0] fault_event_flags;
    logic [15:0] fault_ignore_bits;
    logic [15:0] fault_recovery_select;
    logic [15:0] next_flags;
    logic [15:0] trip;
    logic wr_code;
    logic clear_cmd;
    fsr_pkg::fsr_resp_e resp;

    // fault lines and strap come from the analogue side, so they pass two flops
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fault_sync1 <= 16'h0000;
            fault_sync2 <= 16'h0000;
            strap_sync1 <= 1'b0;
            strap_sync2 <= 1'b0;
        end else begin
            fault_sync1 <= FAULT_IN;
            fault_sync2 <= fault_sync1;
            strap_sync1 <= RECOVERY_STRAP_PIN;
            strap_sync2 <= strap_sync1;
        end
    end

    assign wr_code = REQ.wr;
    assign clear_cmd = REQ.wr && (REQ.code == fsr_pkg::CODE_COMMAND_A);

    // record update: a host write or command_a clears, but a live trigger always wins
    always_comb begin
        next_flags = fault_event_flags;
        if (clear_cmd) begin
            next_flags = 16'h0000;
        end else if (wr_code && REQ.code == fsr_pkg::CODE_FAULT_EVENT_FLAGS) begin
            next_flags = fault_event_flags & REQ.data;
        end
        next_flags = (next_flags | fault_sync2) & fsr_pkg::FAULT_EVENT_FLAGS_USED;
    end

    // sticky record; the mask plays no part here
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fault_event_flags <= fsr_pkg::FAULT_EVENT_FLAGS_RESET;
        end else begin
            fault_event_flags <= next_flags;
        end
    end

    // ignore mask, word wide
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fault_ignore_bits <= fsr_pkg::FAULT_IGNORE_BITS_RESET;
        end else if (wr_code && REQ.code == fsr_pkg::CODE_FAULT_IGNORE_BITS) begin
            fault_ignore_bits <= REQ.data & fsr_pkg::FAULT_IGNORE_BITS_USED;
        end
    end

    // recovery select: strap loads bits 9:2 once after release, then host writes
    // the sync flops reset to zero, so the strap is read only after it has crossed both
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fault_recovery_select <= 16'h0000;
            strap_loaded <= 1'b0;
            strap_wait <= 2'h0;
        end else if (!strap_loaded) begin
            if (strap_wait == fsr_pkg::STRAP_SETTLE_CYCLES) begin
                fault_recovery_select <=
                    {16{strap_sync2}} & fsr_pkg::FAULT_RECOVERY_SELECT_USED;
                strap_loaded <= 1'b1;
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end else if (wr_code && REQ.code == fsr_pkg::CODE_FAULT_RECOVERY_SELECT) begin
            fault_recovery_select <= REQ.data & fsr_pkg::FAULT_RECOVERY_SELECT_USED;
        end
    end

    // threshold bytes keep only their low three bits
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            THRESH.output_overvoltage <= fsr_pkg::OUTPUT_OVERVOLTAGE_THRESHOLD_RESET[2:0];
            THRESH.output_undervoltage <= fsr_pkg::OUTPUT_UNDERVOLTAGE_THRESHOLD_RESET[2:0];
            THRESH.input_current_regulation <=
                fsr_pkg::INPUT_CURRENT_REGULATION_THRESHOLD_RESET[2:0];
            THRESH.average_overcurrent <= fsr_pkg::AVERAGE_OVERCURRENT_THRESHOLD_RESET[2:0];
        end else if (wr_code) begin
            case (REQ.code)
                fsr_pkg::CODE_OUTPUT_OVERVOLTAGE_THRESHOLD: begin
                    THRESH.output_overvoltage <= REQ.data[2:0];
                end
                fsr_pkg::CODE_OUTPUT_UNDERVOLTAGE_THRESHOLD: begin
                    THRESH.output_undervoltage <= REQ.data[2:0];
                end
                fsr_pkg::CODE_INPUT_CURRENT_REGULATION_THRESHOLD: begin
                    THRESH.input_current_regulation <= REQ.data[2:0];
                end
                fsr_pkg::CODE_AVERAGE_OVERCURRENT_THRESHOLD: begin
                    THRESH.average_overcurrent <= REQ.data[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // unmasked faults that carry a protective response (warnings have no select bit)
    assign trip = fault_sync2 & ~fault_ignore_bits & fsr_pkg::FAULT_RECOVERY_SELECT_USED;

    // protective response; command_a is deliberately not an input here
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            resp <= fsr_pkg::FSR_RUN;
        end else begin
            case (resp)
                fsr_pkg::FSR_RUN: begin
                    if ((trip & ~fault_recovery_select) != 16'h0000) begin
                        resp <= fsr_pkg::FSR_LATCHED;
                    end else if (trip != 16'h0000) begin
                        resp <= fsr_pkg::FSR_HICCUP;
                    end
                end
                fsr_pkg::FSR_HICCUP: begin
                    if (HICCUP_DONE) begin
                        resp <= fsr_pkg::FSR_RUN; // retry; only the sequencer ends hiccup
                    end
                end
                fsr_pkg::FSR_LATCHED: begin
                    resp <= fsr_pkg::FSR_LATCHED; // only reset leaves latch-off
                end
                default: begin
                    resp <= fsr_pkg::FSR_RUN;
                end
            endcase
        end
    end

    // response outputs registered from the current state
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HICCUP_ACTIVE <= 1'b0;
            LATCH_OFF <= 1'b0;
            PROTECT_ACTIVE <= 1'b0;
        end else begin
            HICCUP_ACTIVE <= (resp == fsr_pkg::FSR_HICCUP);
            LATCH_OFF <= (resp == fsr_pkg::FSR_LATCHED);
            PROTECT_ACTIVE <= (resp != fsr_pkg::FSR_RUN);
        end
    end

    // alert is registered from the next record value, in step with the record, so command_a drops it unless a fault stands
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ALERT_OUTPUT <= 1'b0;
        end else begin
            ALERT_OUTPUT <= (next_flags != 16'h0000);
        end
    end

    // read path: one cycle latency, unknown codes read zero
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
            RVALID <= 1'b0;
        end else begin
            RVALID <= REQ.rd;
            if (REQ.rd) begin
                case (REQ.code)
                    fsr_pkg::CODE_FAULT_EVENT_FLAGS: RDATA <= fault_event_flags;
                    fsr_pkg::CODE_FAULT_IGNORE_BITS: RDATA <= fault_ignore_bits;
                    fsr_pkg::CODE_FAULT_RECOVERY_SELECT: RDATA <= fault_recovery_select;
                    fsr_pkg::CODE_OUTPUT_OVERVOLTAGE_THRESHOLD: begin
                        RDATA <= {13'h0000, THRESH.output_overvoltage};
                    end
                    fsr_pkg::CODE_OUTPUT_UNDERVOLTAGE_THRESHOLD: begin
                        RDATA <= {13'h0000, THRESH.output_undervoltage};
                    end
                    fsr_pkg::CODE_INPUT_CURRENT_REGULATION_THRESHOLD: begin
                        RDATA <= {13'h0000, THRESH.input_current_regulation};
                    end
                    fsr_pkg::CODE_AVERAGE_OVERCURRENT_THRESHOLD: begin
                        RDATA <= {13'h0000, THRESH.average_overcurrent};
                    end
                    default: RDATA <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// ### pkg/fsr_pkg.sv
// package: register codes, field layout, reset values and carrier types for the fault register bank
package fsr_pkg;
    // command codes of the register bank
    localparam logic [7:0] CODE_FAULT_EVENT_FLAGS = 8'hD0;
    localparam logic [7:0] CODE_FAULT_IGNORE_BITS = 8'hD1;
    localparam logic [7:0] CODE_FAULT_RECOVERY_SELECT = 8'hD2;
    localparam logic [7:0] CODE_OUTPUT_OVERVOLTAGE_THRESHOLD = 8'hD3;
    localparam logic [7:0] CODE_OUTPUT_UNDERVOLTAGE_THRESHOLD = 8'hD4;
    localparam logic [7:0] CODE_INPUT_CURRENT_REGULATION_THRESHOLD = 8'hD5;
    localparam logic [7:0] CODE_AVERAGE_OVERCURRENT_THRESHOLD = 8'hD6;
    localparam logic [7:0] CODE_COMMAND_A = 8'h03;

    // fault bit positions
    localparam int BIT_BUS_COMMUNICATION_WARNING = 0;
    localparam int BIT_THERMISTOR_WARNING = 1;
    localparam int BIT_INPUT_OVERVOLTAGE = 2;
    localparam int BIT_THERMISTOR_FAULT = 3;
    localparam int BIT_SECOND_LEVEL_PEAK_OVERCURRENT = 5;
    localparam int BIT_OUTPUT_UNDERVOLTAGE = 6;
    localparam int BIT_OUTPUT_OVERVOLTAGE = 7;
    localparam int BIT_PLL_COMPENSATION_SHORT = 8;
    localparam int BIT_PLL_LOCK_LOSS = 9;

    // implemented-bit masks
    localparam logic [15:0] FAULT_EVENT_FLAGS_USED = 16'h03EF;
    localparam logic [15:0] FAULT_IGNORE_BITS_USED = 16'h03EF;
    localparam logic [15:0] FAULT_RECOVERY_SELECT_USED = 16'h03FC;
    localparam logic [7:0] THRESHOLD_USED = 8'h07;

    // reset values
    localparam logic [15:0] FAULT_EVENT_FLAGS_RESET = 16'h0000;
    localparam logic [15:0] FAULT_IGNORE_BITS_RESET = 16'h0049;
    localparam logic [7:0] OUTPUT_OVERVOLTAGE_THRESHOLD_RESET = 8'h06;
    localparam logic [7:0] OUTPUT_UNDERVOLTAGE_THRESHOLD_RESET = 8'h01;
    localparam logic [7:0] INPUT_CURRENT_REGULATION_THRESHOLD_RESET = 8'h07;
    localparam logic [7:0] AVERAGE_OVERCURRENT_THRESHOLD_RESET = 8'h07;

    // edges after reset release before the synced strap level can be trusted
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // protective response of the converter
    typedef enum logic [1:0] {
        FSR_RUN,
        FSR_HICCUP,
        FSR_LATCHED
    } fsr_resp_e;

    // one register access from the bus transaction engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } fsr_req_s;

    // threshold settings handed to the analogue comparators
    typedef struct packed {
        logic [2:0] output_overvoltage;
        logic [2:0] output_undervoltage;
        logic [2:0] input_current_regulation;
        logic [2:0] average_overcurrent;
    } fsr_thresh_s;
endpackage

// ### testbench/fsr_host.sv
// bus-side model issuing one-cycle register requests
`timescale 1ns/10ps
module fsr_host (
    input wire logic clk,
    output fsr_pkg::fsr_req_s req
);
    initial req = '0;
    // idle data is inverted so a stale value is never mistaken for a live one
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        req <= {w, ~w, c, d};
        @(negedge clk);
        req <= {2'b00, c, ~d};
    endtask
endmodule

// ### testbench/fsr_regs_sva.sv
// assertion checker for the fault register bank ports
`timescale 1ns/10ps
module fsr_regs_sva (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire fsr_pkg::fsr_req_s REQ,
    input wire logic [15:0] FAULT_IN,
    input wire logic HICCUP_DONE,
    input wire logic [15:0] RDATA,
    input wire logic RVALID,
    input wire logic ALERT_OUTPUT,
    input wire logic HICCUP_ACTIVE,
    input wire logic LATCH_OFF,
    input wire fsr_pkg::fsr_thresh_s THRESH
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // read answers come exactly one cycle after the request
    read_answer_a: assert property (REQ.rd |=> RVALID)
        else $error("read not answered");
    unused_zero_a: assert property (RVALID |-> RDATA[15:10] == 6'h00)
        else $error("unused bits read nonzero");
    thresh_write_a: assert property (REQ.wr && REQ.code == 8'hD3 |=>
        THRESH.output_overvoltage == $past(REQ.data[2:0])) else $error("threshold not written");
    // two sync flops, then the record and the alert on the third edge
    trip_alert_a: assert property ((FAULT_IN & 16'h03EF) != 16'h0000 |-> ##3 ALERT_OUTPUT)
        else $error("fault not recorded");
    alert_hold_a: assert property (ALERT_OUTPUT && !REQ.wr |=> ALERT_OUTPUT)
        else $error("record dropped");
    clear_release_a: assert property ((FAULT_IN == 16'h0000) [*3] ##0
        (REQ.wr && REQ.code == 8'h03) |=> !ALERT_OUTPUT) else $error("alert not released");
    latch_hold_a: assert property (LATCH_OFF |=> LATCH_OFF)
        else $error("latch released");
    // the done pulse is seen one cycle late at the output, hence the past term
    hiccup_hold_a: assert property (HICCUP_ACTIVE && !HICCUP_DONE && !$past(HICCUP_DONE)
        |=> HICCUP_ACTIVE || LATCH_OFF) else $error("hiccup left early");
endmodule
bind fsr_regs fsr_regs_sva u_fsr_regs_sva (.CLK_SYS, .RST_N, .REQ, .FAULT_IN, .HICCUP_DONE,
    .RDATA, .RVALID, .ALERT_OUTPUT, .HICCUP_ACTIVE, .LATCH_OFF, .THRESH);

// ### testbench/tb_top.sv
// self-checking bench for the fault register bank
`timescale 1ns/10ps
module tb_top;
    logic CLK_SYS = 0;
    logic RST_N = 0;
    fsr_pkg::fsr_req_s REQ;
    logic [15:0] FAULT_IN = 16'h0000;
    logic HICCUP_DONE = 0;
    logic strap = 1;
    logic [15:0] RDATA;
    logic RVALID, ALERT_OUTPUT, PROTECT_ACTIVE, HICCUP_ACTIVE, LATCH_OFF;
    fsr_pkg::fsr_thresh_s THRESH;
    logic [15:0] exp_q[$];
    logic [15:0] lfsr = 16'h0032;
    int fails = 0;
    int cmp_count = 0;
    initial forever #20 CLK_SYS = ~CLK_SYS;
    fsr_host u_fsr_host (.clk(CLK_SYS), .req(REQ));
    // strap starts high (all hiccup); a later reset with it low checks latch-off loading
    fsr_regs u_fsr_regs (.CLK_SYS, .RST_N, .REQ, .FAULT_IN, .RECOVERY_STRAP_PIN(strap),
        .HICCUP_DONE, .RDATA, .RVALID, .ALERT_OUTPUT, .PROTECT_ACTIVE, .HICCUP_ACTIVE,
        .LATCH_OFF, .THRESH);
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, want, seen);
        end
    endtask
    task automatic wrap_up();
        if (exp_q.size() != 0) fails++;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rd(input logic [7:0] c, input logic [15:0] want);
        exp_q.push_back(want);
        u_fsr_host.send(1'b0, c, 16'h0000);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask
    // read data is settled by the falling edge; oldest note first
    always @(negedge CLK_SYS) begin
        if (RVALID === 1'b1) begin
            if (exp_q.size() == 0) check("read count", 16'h0001, 16'h0000);
            else check("rdata", RDATA, exp_q.pop_front());
        end
    end
    // cuts a hang short
    initial begin
        repeat (3000) @(posedge CLK_SYS);
        fails++;
        wrap_up();
    end
    initial begin
        logic [7:0] codes[8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7};
        logic [15:0] rst[8] = '{16'h0, 16'h49, 16'h3FC, 16'h6, 16'h1, 16'h7, 16'h7, 16'h0};
        logic [15:0] used[8] = '{16'h0, 16'h3EF, 16'h3FC, 16'h7, 16'h7, 16'h7, 16'h7, 16'h0};
        repeat (6) @(posedge CLK_SYS);
        @(negedge CLK_SYS) RST_N = 1;
        cyc(1);
        check("thresh", {4'h0, THRESH}, {4'h0, 3'h6, 3'h1, 3'h7, 3'h7});
        for (int i = 0; i < 8; i++) rd(codes[i], rst[i]);
        // random words; unused bits and the write-ones of the record must vanish
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            u_fsr_host.send(1'b1, codes[i], lfsr);
            rd(codes[i], lfsr & used[i]);
        end
        u_fsr_host.send(1'b1, 8'hD1, 16'h0040);
        u_fsr_host.send(1'b1, 8'hD2, 16'h0080);
        FAULT_IN = 16'h0080;
        cyc(5);
        check("hiccup", 16'(HICCUP_ACTIVE), 16'h0001);
        FAULT_IN = 16'h0000;
        cyc(3);
        rd(8'hD0, 16'h0080);
        u_fsr_host.send(1'b1, 8'h03, 16'h0000);
        cyc(1);
        check("alert", 16'(ALERT_OUTPUT), 16'h0000);
        check("hiccup kept", 16'(HICCUP_ACTIVE), 16'h0001);
        rd(8'hD0, 16'h0000);
        HICCUP_DONE = 1;
        cyc(1);
        HICCUP_DONE = 0;
        cyc(2);
        check("hiccup end", 16'(HICCUP_ACTIVE), 16'h0000);
        FAULT_IN = 16'h0040;
        cyc(5);
        check("protect", 16'(PROTECT_ACTIVE), 16'h0000);
        FAULT_IN = 16'h0000;
        rd(8'hD0, 16'h0040);
        u_fsr_host.send(1'b1, 8'hD0, 16'hFFBF);
        rd(8'hD0, 16'h0000);
        FAULT_IN = 16'h0004;
        cyc(5);
        check("latch", 16'(LATCH_OFF), 16'h0001);
        FAULT_IN = 16'h0000;
        u_fsr_host.send(1'b1, 8'h03, 16'h0000);
        cyc(2);
        check("latch kept", 16'(LATCH_OFF), 16'h0001);
        // second reset with the strap low: latch-off for all, response state cleared
        strap = 0;
        RST_N = 0;
        cyc(6);
        RST_N = 1;
        cyc(3);
        check("latch reset", 16'(LATCH_OFF), 16'h0000);
        rd(8'hD2, 16'h0000);
        cyc(3);
        wrap_up();
    end
endmodule
